// [common/ebp_map.svh]
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH
`define EBP_MODE_SINGLE 2'h0
`define EBP_MODE_HALF 2'h2
`define EBP_MODE_FWD 2'h1
`define EBP_MODE_REV 2'h3
`define EBP_PS_1 2'h0
`define EBP_PS_4 2'h1
`define EBP_DIV4_MAX 2'h3
`define EBP_DIV16_MAX 4'hf
`define EBP_PWM_ON 4'hc
`define EBP_ZERO10 10'h000
`define EBP_ZERO8 8'h00
`define EBP_ZERO7 7'h00
`endif

// [common/ebp_pkg.sv]
`default_nettype none
package ebp_pkg;
    typedef enum logic [1:0] {
        EBP_SINGLE = 2'b00,
        EBP_FWD = 2'b01,
        EBP_HALF = 2'b10,
        EBP_REV = 2'b11
    } ebp_mode_t;
    typedef enum logic [0:0] {
        EBP_ARMED = 1'b0,
        EBP_RUN = 1'b1
    } ebp_state_t;
endpackage : ebp_pkg
`default_nettype wire

// [hw/ebp_pwm.sv]
// What this block does
// - sleep stops the period timer and freezes internal state; flag_clear still clears the period flag.
// - outputs driving a level keep that level through sleep.
// - after wake the timer continues from its held value.
// - time base runs from the system clock only.
// - reset makes all pins inputs and registers reset values.
// - mode field 00 single, 10 half, 01 forward, 11 reverse.
// - up to four outputs, duty resolution ten bits.
// - single mode drives outputs selected by steering.
// - output polarity chosen by unit mode bits.
// - first enable waits for a new period before modulated output; forward/reverse active pin drives at once.
// - control cleared to zero releases all four pins.
// - pins unused by the mode are not driven by the block.
// - half bridge: waveform on A, complement on B, C and D unused.
// - half bridge dead-band delays each rising edge by count instruction cycles (four clocks each).
// - dead-band above duty keeps that output inactive all cycle.
// - forward: A active, D modulated, B and C inactive.
// - reverse: C active, B modulated, A and D inactive.
// - prescaler divides by 1, 4 or 16.
// - at timer equal period: clear timer, set output unless the new duty is zero, latch duty.
// - pulse ends when 10-bit time base equals latched duty.
`default_nettype none
`include "ebp_map.svh"
module ebp_pwm (
    input wire logic mclk, // system clock
    input wire logic rst, // sync reset
    input wire logic sleep, // device asleep
    input wire logic [1:0] output_mode_select, // bridge mode
    input wire logic [3:0] unit_mode_bits, // 11xx pwm, [1] polarity ac, [0] bd
    input wire logic [7:0] duty_upper_bits, // duty msbs
    input wire logic [1:0] duty_lower_bits, // duty lsbs
    input wire logic [6:0] deadband_count, // dead-band in 4-clock instruction cycles
    input wire logic [7:0] period_register, // period
    input wire logic period_timer_run, // timer enable
    input wire logic [1:0] period_prescale_select, // 0:1, 1:4, else 16
    input wire logic [3:0] steer_enable, // single mode steering a..d
    input wire logic [3:0] pin_direction_bit, // 1 input, 0 output per pin
    input wire logic flag_clear, // clears period_timer_flag
    output logic [3:0] pinOut, // a..d level
    output logic [3:0] pinOe, // a..d drive enable
    output logic period_timer_flag, // timer matched period
    output logic [7:0] period_timer_count // timer value
);
    logic [3:0] psCnt_r;
    logic [1:0] phase_r;
    logic tick;
    logic [9:0] dutyLatch_r;
    logic [9:0] timeBase;
    logic pwm_r;
    logic pulseOn;
    logic pwmOn;
    logic [3:0] wave;
    logic [3:0] useMask;
    logic [6:0] dbA_r;
    logic [6:0] dbB_r;
    logic wasOn_r;
    logic startNew;
    ebp_pkg::ebp_state_t state_r;
    ebp_pkg::ebp_mode_t mode;

    assign mode = ebp_pkg::ebp_mode_t'(output_mode_select);
    assign pwmOn = (unit_mode_bits[3:2] == 2'b11) && (pwm_control_nz());

    function automatic logic pwm_control_nz();
        pwm_control_nz = (unit_mode_bits != 4'h0) || (output_mode_select != 2'h0);
    endfunction : pwm_control_nz

    // prescaler: tick enables one timer increment (4 clocks per instruction)
    always_comb begin
        if (period_prescale_select == `EBP_PS_1) begin
            tick = (psCnt_r[1:0] == `EBP_DIV4_MAX);
        end else if (period_prescale_select == `EBP_PS_4) begin
            tick = (psCnt_r[3:0] == `EBP_DIV16_MAX);
        end else begin
            tick = (psCnt_r[3:0] == `EBP_DIV16_MAX) && (phase_r == `EBP_DIV4_MAX);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            psCnt_r <= 4'h0;
            phase_r <= 2'h0;
        end else if (!sleep && period_timer_run) begin
            psCnt_r <= psCnt_r + 4'h1;
            if (psCnt_r == `EBP_DIV16_MAX) begin
                phase_r <= phase_r + 2'h1;
            end
        end
    end

    // two extra time-base bits: clock phase at 1:1, prescaler bits otherwise
    always_comb begin
        if (period_prescale_select == `EBP_PS_1) begin
            timeBase = {period_timer_count, psCnt_r[1:0]};
        end else if (period_prescale_select == `EBP_PS_4) begin
            timeBase = {period_timer_count, psCnt_r[3:2]};
        end else begin
            timeBase = {period_timer_count, phase_r};
        end
    end

    assign startNew = tick && (period_timer_count == period_register);

    // pulse drops in the very cycle the time base meets the duty
    assign pulseOn = pwm_r && (timeBase != dutyLatch_r);

    always_ff @(posedge mclk) begin
        if (rst) begin
            period_timer_count <= `EBP_ZERO8;
        end else if (!sleep && period_timer_run && tick) begin
            if (startNew) begin
                period_timer_count <= `EBP_ZERO8;
            end else begin
                period_timer_count <= period_timer_count + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            period_timer_flag <= 1'b0;
        end else if (!sleep && period_timer_run && startNew) begin
            period_timer_flag <= 1'b1; // set wins over clear
        end else if (flag_clear) begin
            period_timer_flag <= 1'b0;
        end
    end

    // duty double buffer and armed/run sequencing
    always_ff @(posedge mclk) begin
        if (rst) begin
            dutyLatch_r <= `EBP_ZERO10;
            state_r <= ebp_pkg::EBP_ARMED;
            pwm_r <= 1'b0;
            wasOn_r <= 1'b0;
        end else if (!sleep) begin
            wasOn_r <= pwmOn;
            if (!pwmOn) begin
                state_r <= ebp_pkg::EBP_ARMED;
                pwm_r <= 1'b0;
            end else if (period_timer_run && startNew) begin
                dutyLatch_r <= {duty_upper_bits, duty_lower_bits};
                state_r <= ebp_pkg::EBP_RUN;
                pwm_r <= ({duty_upper_bits, duty_lower_bits} != `EBP_ZERO10);
            end else if (period_timer_run && timeBase == dutyLatch_r) begin
                pwm_r <= 1'b0;
            end
        end
    end

    // dead-band counters: rising edge of each half-bridge side waits
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbA_r <= `EBP_ZERO7;
            dbB_r <= `EBP_ZERO7;
        end else if (!sleep) begin
            if (!pulseOn) begin
                dbA_r <= `EBP_ZERO7;
            end else if (dbA_r != deadband_count && tick_instr()) begin
                dbA_r <= dbA_r + 7'h01;
            end
            if (pulseOn) begin
                dbB_r <= `EBP_ZERO7;
            end else if (dbB_r != deadband_count && tick_instr()) begin
                dbB_r <= dbB_r + 7'h01;
            end
        end
    end

    function automatic logic tick_instr();
        tick_instr = (psCnt_r[1:0] == `EBP_DIV4_MAX);
    endfunction : tick_instr

    // active-high wave per pin before polarity
    always_comb begin
        wave = 4'h0;
        useMask = 4'h0;
        case (mode)
            ebp_pkg::EBP_SINGLE: begin
                wave = {4{pulseOn}};
                useMask = steer_enable;
            end
            ebp_pkg::EBP_HALF: begin
                // dead-band longer than pulse keeps side inactive
                wave[0] = pulseOn && (dbA_r == deadband_count);
                wave[1] = !pulseOn && (dbB_r == deadband_count) && state_r == ebp_pkg::EBP_RUN;
                useMask = 4'b0011;
            end
            ebp_pkg::EBP_FWD: begin
                wave = {pulseOn, 1'b0, 1'b0, 1'b1};
                useMask = 4'hf;
            end
            ebp_pkg::EBP_REV: begin
                wave = {1'b0, 1'b1, pulseOn, 1'b0};
                useMask = 4'hf;
            end
            default: begin
                wave = 4'h0;
                useMask = 4'h0;
            end
        endcase
    end

    // outputs: held during sleep, released when unit off
    always_ff @(posedge mclk) begin
        if (rst) begin
            pinOut <= 4'h0;
            pinOe <= 4'h0;
        end else if (!sleep) begin
            if (!pwmOn) begin
                pinOut <= 4'h0;
                pinOe <= 4'h0;
            end else begin
                pinOut[0] <= wave[0] ^ unit_mode_bits[1];
                pinOut[2] <= wave[2] ^ unit_mode_bits[1];
                pinOut[1] <= wave[1] ^ unit_mode_bits[0];
                pinOut[3] <= wave[3] ^ unit_mode_bits[0];
                pinOe <= useMask & ~pin_direction_bit;
            end
        end
    end

    chk_sleep_hold: assert property (@(posedge mclk) disable iff (rst)
        sleep && $past(sleep) |-> $stable(period_timer_count) && $stable(pinOut))
        else $error("state moved during sleep");
    chk_pins_hold: assert property (@(posedge mclk) disable iff (rst)
        $past(sleep) |-> pinOe == $past(pinOe))
        else $error("pin enable changed in sleep");
    chk_off_release: assert property (@(posedge mclk) disable iff (rst)
        !sleep && !pwmOn |=> pinOe == 4'h0)
        else $error("pins not released");
    chk_fwd_pins: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && mode == ebp_pkg::EBP_FWD && !unit_mode_bits[1]
        |=> pinOut[0] && !pinOut[2])
        else $error("forward a/c wrong");
    chk_rev_pins: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && mode == ebp_pkg::EBP_REV && !unit_mode_bits[1]
        |=> !pinOut[0] && pinOut[2])
        else $error("reverse a/c wrong");
    chk_half_unused: assert property (@(posedge mclk) disable iff (rst)
        !sleep && mode == ebp_pkg::EBP_HALF |=> pinOe[3:2] == 2'b00)
        else $error("half drives c/d");
    chk_period_wrap: assert property (@(posedge mclk) disable iff (rst)
        !sleep && period_timer_run && startNew
        |=> period_timer_count == 8'h00 && period_timer_flag)
        else $error("period wrap wrong");
    chk_armed_quiet: assert property (@(posedge mclk) disable iff (rst)
        state_r == ebp_pkg::EBP_ARMED |-> !pwm_r)
        else $error("output before period start");
    chk_duty_end: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && period_timer_run && !startNew && timeBase == dutyLatch_r
        |=> !pwm_r)
        else $error("pulse not ended");

    chk_single_steer: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && mode == ebp_pkg::EBP_SINGLE
        |=> pinOe == ($past(steer_enable) & ~$past(pin_direction_bit)))
        else $error("single steering wrong");
    chk_half_excl: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && mode == ebp_pkg::EBP_HALF && unit_mode_bits[1:0] == 2'b00
        |=> !(pinOut[0] && pinOut[1]))
        else $error("half sides both active");
    chk_fwd_inact: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && mode == ebp_pkg::EBP_FWD && !unit_mode_bits[0]
        |=> !pinOut[1])
        else $error("forward b active");
    chk_rev_inact: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && mode == ebp_pkg::EBP_REV && !unit_mode_bits[0]
        |=> !pinOut[3])
        else $error("reverse d active");
    chk_reset_vals: assert property (@(posedge mclk)
        rst |=> pinOe == 4'h0 && period_timer_count == 8'h00 && !period_timer_flag)
        else $error("reset values wrong");
    chk_wake_resume: assert property (@(posedge mclk) disable iff (rst)
        !sleep && $past(sleep) |-> period_timer_count == $past(period_timer_count))
        else $error("timer moved at wake");
    chk_state_freeze: assert property (@(posedge mclk) disable iff (rst)
        sleep && $past(sleep) |-> $stable(dutyLatch_r) && $stable(state_r))
        else $error("pwm state moved in sleep");
    chk_zero_duty: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && period_timer_run && startNew
        && {duty_upper_bits, duty_lower_bits} == 10'h000 |=> !pwm_r)
        else $error("zero duty set output");
    chk_duty_latch: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn && period_timer_run && startNew
        |=> dutyLatch_r == $past({duty_upper_bits, duty_lower_bits}))
        else $error("duty not latched");
    chk_oe_dir: assert property (@(posedge mclk) disable iff (rst)
        !sleep && pwmOn |=> (pinOe & $past(pin_direction_bit)) == 4'h0)
        else $error("input pin driven");
    chk_timer_idle: assert property (@(posedge mclk) disable iff (rst)
        !sleep && !period_timer_run |=> $stable(period_timer_count))
        else $error("timer moved while stopped");

    cov_half: cover property (@(posedge mclk) mode == ebp_pkg::EBP_HALF && pinOut[0]);
    cov_fwd: cover property (@(posedge mclk) mode == ebp_pkg::EBP_FWD && pwm_r);
    cov_sleep: cover property (@(posedge mclk) sleep && pwm_r);
    cov_wrap: cover property (@(posedge mclk) startNew && state_r == ebp_pkg::EBP_RUN);
    cov_rev: cover property (@(posedge mclk) mode == ebp_pkg::EBP_REV && pwm_r);

endmodule : ebp_pwm
`default_nettype wire

// [dv/ebp_bridge_model.sv]
`default_nettype none
module ebp_bridge_model (
    input wire logic [3:0] pinOut, // block pin levels
    input wire logic [3:0] pinOe, // block drive enables
    output logic [3:0] gate, // switch gate levels seen
    output logic shoot // both switches of leg a/b on
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven pins fall to the board pull-downs, switches stay off
    assign gate = pinOut & pinOe;
    assign shoot = gate[0] & gate[1];
endmodule : ebp_bridge_model
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1, sleepReq = 1'b0, timerRun = 1'b0, flagClear = 1'b0;
    logic [1:0] modeSel = 2'h0, dutyLo = 2'h0, prescale = 2'h0;
    logic [3:0] unitMode = 4'h0, steer = 4'h1, pinDir = 4'hf, pinOut, pinOe, gate;
    logic [7:0] dutyHi = 8'h00, periodVal = 8'h09, timerCount;
    logic [6:0] deadCnt = 7'h00;
    logic timerFlag, shoot;
    logic [7:0] held;
    int num_errors = 0, num_checks = 0;
    always #5 mclk = ~mclk;
    ebp_pwm ebp_pwm_inst (.mclk(mclk), .rst(rst), .sleep(sleepReq),
        .output_mode_select(modeSel), .unit_mode_bits(unitMode), .duty_upper_bits(dutyHi),
        .duty_lower_bits(dutyLo), .deadband_count(deadCnt), .period_register(periodVal),
        .period_timer_run(timerRun), .period_prescale_select(prescale), .steer_enable(steer),
        .pin_direction_bit(pinDir), .flag_clear(flagClear), .pinOut(pinOut), .pinOe(pinOe),
        .period_timer_flag(timerFlag), .period_timer_count(timerCount));
    ebp_bridge_model ebp_bridge_model_inst (.pinOut(pinOut), .pinOe(pinOe), .gate(gate),
        .shoot(shoot));
    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : chk
    task wait_flag;
        int i;
        @(negedge mclk) flagClear = 1'b1;
        @(negedge mclk) flagClear = 1'b0;
        for (i = 0; i < 4000 && timerFlag !== 1'b1; i++) @(negedge mclk);
        if (i == 4000) begin
            num_errors++;
            $display("[ERR] %0t period flag never set", $time);
            conclude();
        end
    endtask : wait_flag
    // count high cycles of each gate over a whole number of periods
    task run(input logic [1:0] m, input logic [3:0] u, input logic [1:0] ps,
            input logic [6:0] db, input logic [9:0] d, input int win,
            input logic [3:0] expOe, input logic [63:0] expHi);
        logic [3:0][15:0] hi;
        logic [15:0] sh;
        hi = '0;
        sh = 16'h0000;
        pinDir = 4'hf;
        modeSel = m;
        unitMode = u;
        {dutyHi, dutyLo} = d;
        deadCnt = db;
        prescale = ps;
        timerRun = 1'b1;
        wait_flag();
        pinDir = 4'h0;
        wait_flag();
        repeat (win) begin
            @(negedge mclk);
            for (int k = 0; k < 4; k++) hi[k] += {15'h0000, gate[k]};
            sh += {15'h0000, shoot};
        end
        chk({12'h000, pinOe}, {12'h000, expOe}, "drive enables");
        for (int k = 0; k < 4; k++) chk(hi[k], expHi[k*16+:16], "high cycles");
        chk(sh, 16'h0000, "shoot-through cycles");
    endtask : run
    task sleep_hold;
        logic [3:0] lvl;
        int i;
        for (i = 0; i < 1000 && timerCount !== 8'h04; i++) @(negedge mclk);
        if (i == 1000) begin
            num_errors++;
            $display("[ERR] %0t timer never reached sleep point", $time);
            conclude();
        end
        sleepReq = 1'b1;
        lvl = pinOut;
        held = timerCount;
        repeat (30) @(negedge mclk);
        chk({8'h00, timerCount}, {8'h00, held}, "count in sleep");
        chk({12'h000, pinOut}, {12'h000, lvl}, "pins in sleep");
        sleepReq = 1'b0;
        @(negedge mclk);
        chk({15'h0000, timerCount inside {8'h04, 8'h05}}, 16'h0001, "count after wake");
    endtask : sleep_hold
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        chk({4'h0, pinOe, timerCount}, 16'h0000, "after reset");
        run(2'h0, 4'hc, 2'h0, 7'h00, 10'h014, 40, 4'h1, {16'd0, 16'd0, 16'd0, 16'd20});
        run(2'h2, 4'hc, 2'h0, 7'h02, 10'h014, 40, 4'h3, {16'd0, 16'd0, 16'd12, 16'd12});
        run(2'h2, 4'hc, 2'h0, 7'h06, 10'h014, 40, 4'h3, {64'd0});
        run(2'h1, 4'hc, 2'h0, 7'h00, 10'h014, 40, 4'hf, {16'd20, 16'd0, 16'd0, 16'd40});
        run(2'h3, 4'hc, 2'h0, 7'h00, 10'h014, 40, 4'hf, {16'd0, 16'd40, 16'd20, 16'd0});
        run(2'h1, 4'hf, 2'h0, 7'h00, 10'h00c, 40, 4'hf, {16'd28, 16'd40, 16'd40, 16'd0});
        run(2'h0, 4'hc, 2'h1, 7'h00, 10'h014, 160, 4'h1, {16'd0, 16'd0, 16'd0, 16'd80});
        run(2'h0, 4'hc, 2'h2, 7'h00, 10'h014, 640, 4'h1, {16'd0, 16'd0, 16'd0, 16'd320});
        sleep_hold();
        unitMode = 4'h0;
        repeat (3) @(negedge mclk);
        chk({12'h000, pinOe}, 16'h0000, "released pins");
        unitMode = 4'hc;
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        chk({3'h0, timerFlag, pinOe, timerCount}, 16'h0000, "mid-run reset");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
